/* File: rtl/spcc_consts.vh */
// Constants for the serial port control and configuration block
`ifndef SPCC_CONSTS_VH
`define SPCC_CONSTS_VH
`define SPCC_OFF_CTRL    8'h00
`define SPCC_OFF_TXDATA  8'h04
`define SPCC_OFF_RXDATA  8'h08
`define SPCC_OFF_STATUS  8'h0C
`define SPCC_OFF_IRQEN   8'h10
`define SPCC_OFF_IRQCLR  8'h14
`define SPCC_OFF_AUX     8'h18
`define SPCC_CTRL_RESET  32'h0000_0000
`define SPCC_CTRL_MASK   32'h0000_BFEF
`define SPCC_BIT_ON      15
`define SPCC_BIT_IDLE_STOP    13
`define SPCC_BIT_DISSO   12
`define SPCC_BIT_W32     11
`define SPCC_BIT_W16     10
`define SPCC_BIT_SMP     9
`define SPCC_BIT_CKE     8
`define SPCC_BIT_SELECT_PIN_ENABLE    7
`define SPCC_BIT_CKP     6
`define SPCC_BIT_MST     5
`define SPCC_TXM_HI      3
`define SPCC_TXM_LO      2
`define SPCC_RXM_HI      1
`define SPCC_RXM_LO      0
`define SPCC_BIT_FRM     0
`define SPCC_EV_TX       0
`define SPCC_EV_RX       1
`define SPCC_EV_OVF      2
`define SPCC_NEV         3
`define SPCC_DEPTH       3'h4
`define SPCC_HALF_DEPTH  3'h2
`define SPCC_CLK_NS      40
`define SPCC_SCK_HALF_NS 80
`define SPCC_IM_ANY      2'h3
`define SPCC_IM_HALF     2'h2
`define SPCC_IM_ONE      2'h1
`define SPCC_IM_LAST     2'h0
`define SPCC_BITS8       6'h07
`define SPCC_BITS16      6'h0F
`define SPCC_BITS32      6'h1F
`endif

/* File: rtl/spcc_top.v */
// Serial port control, configuration and shift engine with APB slave
//
// Contract
// - The port works only while the enable bit 15 of the control register is 1.
// - With idle_stop set the port halts while the processor is idle.
// - With serial_out_disable set the port releases the serial data output pin.
// - Word width is 32 bits if word32_select, else 16 if word16_select, else 8.
// - A master samples input mid-period, or at period end when input_sample_phase is 1.
// - A slave ignores input_sample_phase and always samples mid-period.
// - clock_edge_select 1 changes output on active-to-idle, 0 on idle-to-active.
// - A slave uses the select pin only when select_pin_enable is 1.
// - clock_polarity 1 makes the clock idle high, 0 idle low.
// - master_select 1 makes the port master, 0 slave.
// - tx_irq_mode picks any-free, half-empty, empty or transmit-complete.
// - rx_irq_mode picks full, half-full, not-empty or last-word-read.
// - In framed mode clock_edge_select is not used.
// - Control bits 14 and 4 read as zero.
`timescale 1ns/10ps
`default_nettype none
`include "spcc_consts.vh"
module spcc_top
(
    input  wire        mclk_in,
    input  wire        reset_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [7:0]  paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output wire        pready_out,
    output wire        pslverr_out,
    input  wire        cpu_idle_in,
    input  wire        sck_in,
    input  wire        sdi_in,
    input  wire        select_n_in,
    output wire        sck_out,
    output wire        sck_oe_out,
    output wire        sdo_out,
    output wire        sdo_oe_out,
    output wire        irq_out
);
    localparam [31:0] HALF_CYC = `SPCC_SCK_HALF_NS / `SPCC_CLK_NS;
    localparam        ST_IDLE  = 1'b0;
    localparam        ST_RUN   = 1'b1;

    reg  [31:0] ctrl;
    reg         framed;
    reg  [2:0]  irq_stat;
    reg  [2:0]  irq_en;
    reg  [31:0] tx_mem [0:3];
    reg  [31:0] rx_mem [0:3];
    reg  [1:0]  tx_wp, tx_rp, rx_wp, rx_rp;
    reg  [2:0]  tx_cnt, rx_cnt;
    reg  [2:0]  sck_s, sdi_s, sel_s;
    reg  [31:0] sh, rx_sh;
    reg  [5:0]  bitcnt;
    reg  [3:0]  hcnt;
    reg         half, state, loaded, sampled;

    wire        setup   = psel_in & ~penable_in;
    wire        access  = psel_in & penable_in;
    wire        wr      = access & pwrite_in;
    wire        mapped  = (paddr_in[7:2] <= `SPCC_OFF_AUX >> 2) & (paddr_in[1:0] == 2'h0);
    wire        on      = ctrl[`SPCC_BIT_ON];
    wire        halted  = ctrl[`SPCC_BIT_IDLE_STOP] & cpu_idle_in;
    wire        master  = ctrl[`SPCC_BIT_MST];
    wire        cpol    = ctrl[`SPCC_BIT_CKP];
    wire        cke     = ctrl[`SPCC_BIT_CKE] & ~framed;
    wire        input_sample_phase     = ctrl[`SPCC_BIT_SMP] & master;
    wire [1:0]  txm     = ctrl[`SPCC_TXM_HI:`SPCC_TXM_LO];
    wire [1:0]  rxm     = ctrl[`SPCC_RXM_HI:`SPCC_RXM_LO];
    wire [5:0]  last    = ctrl[`SPCC_BIT_W32] ? `SPCC_BITS32 :
                          ctrl[`SPCC_BIT_W16] ? `SPCC_BITS16 : `SPCC_BITS8;
    wire        sel     = ~ctrl[`SPCC_BIT_SELECT_PIN_ENABLE] | ~sel_s[1];
    wire        slv_on  = on & ~master & sel;
    wire        lead    = (sck_s[2] == cpol) & (sck_s[1] != cpol);
    wire        trail   = (sck_s[2] != cpol) & (sck_s[1] == cpol);
    wire        smp_edg = cke ? lead : trail;
    wire        sft_edg = cke ? trail : lead;
    wire        hend    = (hcnt == HALF_CYC[3:0] - 4'h1);
    wire        tx_push = wr & (paddr_in == `SPCC_OFF_TXDATA) & (tx_cnt != `SPCC_DEPTH);
    wire        rx_pop  = access & ~pwrite_in & (paddr_in == `SPCC_OFF_RXDATA)
                          & (rx_cnt != 3'h0);
    wire        m_start = on & ~halted & master & (state == ST_IDLE) & (tx_cnt != 3'h0);
    wire        s_load  = slv_on & ~halted & ~loaded;
    wire        tx_pop  = m_start | (s_load & (tx_cnt != 3'h0));
    wire        m_done  = (state == ST_RUN) & hend & half & (bitcnt == last);
    wire        s_done  = slv_on & ~halted & loaded & smp_edg & (bitcnt == last);
    wire        rx_push = (m_done | s_done) & ~halted;
    wire        rx_full = (rx_cnt == `SPCC_DEPTH);
    reg         tx_cond, rx_cond;
    wire [2:0]  ev_set;
    wire [31:0] left_tx;

    assign pready_out  = 1'b1;
    assign pslverr_out = access & ~mapped;
    assign irq_out     = |(irq_stat & irq_en);
    assign sck_oe_out  = on & master;
    assign sck_out     = (state == ST_RUN) ? (cpol ^ (cke ? half : ~half)) : cpol;
    assign sdo_out     = sh[31];
    assign sdo_oe_out  = on & ~ctrl[`SPCC_BIT_DISSO] & (master | sel);
    assign left_tx     = ctrl[`SPCC_BIT_W32] ? tx_mem[tx_rp] :
                         ctrl[`SPCC_BIT_W16] ? {tx_mem[tx_rp][15:0], 16'h0000} :
                         {tx_mem[tx_rp][7:0], 24'h00_0000};

    always @*
    begin
        case (txm)
            `SPCC_IM_ANY:  tx_cond = (tx_cnt != `SPCC_DEPTH);
            `SPCC_IM_HALF: tx_cond = (tx_cnt <= `SPCC_HALF_DEPTH);
            `SPCC_IM_ONE:  tx_cond = (tx_cnt == 3'h0);
            default:       tx_cond = (tx_cnt == 3'h0) & (state == ST_IDLE) & ~loaded;
        endcase
        case (rxm)
            `SPCC_IM_ANY:  rx_cond = rx_full;
            `SPCC_IM_HALF: rx_cond = (rx_cnt >= `SPCC_HALF_DEPTH);
            `SPCC_IM_ONE:  rx_cond = (rx_cnt != 3'h0);
            default:       rx_cond = (rx_cnt == 3'h0);
        endcase
    end

    assign ev_set[`SPCC_EV_TX]  = on & tx_cond;
    assign ev_set[`SPCC_EV_RX]  = on & rx_cond;
    assign ev_set[`SPCC_EV_OVF] = rx_push & rx_full;

    // Sticky status, set wins over clear
    genvar g;
    generate
        for (g = 0; g < `SPCC_NEV; g = g + 1)
        begin : g_ev
            always @(posedge mclk_in or posedge reset_in)
            begin
                if (reset_in)
                    irq_stat[g] <= 1'b0;
                else if (ev_set[g])
                    irq_stat[g] <= 1'b1;
                else if (wr & (paddr_in == `SPCC_OFF_IRQCLR) & pwdata_in[g])
                    irq_stat[g] <= 1'b0;
            end
        end
    endgenerate

    // Link pins through two flops; third stage for edges
    always @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            sck_s <= 3'h0;
            sdi_s <= 3'h0;
            sel_s <= 3'h7;
        end
        else
        begin
            sck_s <= {sck_s[1:0], sck_in};
            sdi_s <= {sdi_s[1:0], sdi_in};
            sel_s <= {sel_s[1:0], select_n_in};
        end
    end

    // Register file and buffers
    always @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ctrl       <= `SPCC_CTRL_RESET;
            framed     <= 1'b0;
            irq_en     <= 3'h0;
            prdata_out <= 32'h0000_0000;
            tx_wp      <= 2'h0;
            tx_rp      <= 2'h0;
            rx_wp      <= 2'h0;
            rx_rp      <= 2'h0;
            tx_cnt     <= 3'h0;
            rx_cnt     <= 3'h0;
        end
        else
        begin
            if (wr & (paddr_in == `SPCC_OFF_CTRL))
                ctrl <= pwdata_in & `SPCC_CTRL_MASK;
            if (wr & (paddr_in == `SPCC_OFF_AUX))
                framed <= pwdata_in[`SPCC_BIT_FRM];
            if (wr & (paddr_in == `SPCC_OFF_IRQEN))
                irq_en <= pwdata_in[2:0];
            if (setup)
            begin
                case (paddr_in)
                    `SPCC_OFF_CTRL:   prdata_out <= ctrl;
                    `SPCC_OFF_RXDATA: prdata_out <= rx_mem[rx_rp];
                    `SPCC_OFF_STATUS: prdata_out <= {15'h0000, state | loaded, 1'b0,
                                                     rx_cnt, 1'b0, tx_cnt, 5'h00, irq_stat};
                    `SPCC_OFF_IRQEN:  prdata_out <= {29'h0000_0000, irq_en};
                    `SPCC_OFF_AUX:    prdata_out <= {31'h0000_0000, framed};
                    default:          prdata_out <= 32'h0000_0000;
                endcase
            end
            if (tx_push)
            begin
                tx_mem[tx_wp] <= pwdata_in;
                tx_wp         <= tx_wp + 2'h1;
            end
            if (tx_pop)
                tx_rp <= tx_rp + 2'h1;
            tx_cnt <= tx_cnt + {2'h0, tx_push} - {2'h0, tx_pop};
            if (rx_push & ~rx_full)
            begin
                rx_mem[rx_wp] <= smp_edg & ~master ? {rx_sh[30:0], sdi_s[1]} :
                                 (input_sample_phase & half ? {rx_sh[30:0], sdi_s[1]} : rx_sh);
                rx_wp         <= rx_wp + 2'h1;
            end
            if (rx_pop)
                rx_rp <= rx_rp + 2'h1;
            rx_cnt <= rx_cnt + {2'h0, rx_push & ~rx_full} - {2'h0, rx_pop};
        end
    end

    // Shift engine, master and slave
    always @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state   <= ST_IDLE;
            sh      <= 32'h0000_0000;
            rx_sh   <= 32'h0000_0000;
            bitcnt  <= 6'h00;
            hcnt    <= 4'h0;
            half    <= 1'b0;
            loaded  <= 1'b0;
            sampled <= 1'b0;
        end
        else if (~on)
        begin
            state   <= ST_IDLE;
            bitcnt  <= 6'h00;
            loaded  <= 1'b0;
            sampled <= 1'b0;
        end
        else if (~halted)
        begin
            case (state)
                ST_IDLE:
                begin
                    if (m_start)
                    begin
                        state  <= ST_RUN;
                        sh     <= left_tx;
                        rx_sh  <= 32'h0000_0000;
                        bitcnt <= 6'h00;
                        hcnt   <= 4'h0;
                        half   <= 1'b0;
                    end
                    else if (~master)
                    begin
                        if (~sel)
                        begin
                            bitcnt <= 6'h00;
                            loaded <= 1'b0;
                        end
                        else if (~loaded)
                        begin
                            sh      <= (tx_cnt != 3'h0) ? left_tx : 32'h0000_0000;
                            rx_sh   <= 32'h0000_0000;
                            loaded  <= 1'b1;
                            sampled <= 1'b0;
                            bitcnt  <= 6'h00;
                        end
                        else if (smp_edg)
                        begin
                            rx_sh   <= {rx_sh[30:0], sdi_s[1]};
                            sampled <= 1'b1;
                            bitcnt  <= bitcnt + 6'h01;
                            if (bitcnt == last)
                                loaded <= 1'b0;
                        end
                        else if (sft_edg & sampled)
                        begin
                            sh      <= {sh[30:0], 1'b0};
                            sampled <= 1'b0;
                        end
                    end
                end
                default:
                begin
                    hcnt <= hend ? 4'h0 : hcnt + 4'h1;
                    if (hend)
                    begin
                        half <= ~half;
                        if (~half & ~input_sample_phase)
                            rx_sh <= {rx_sh[30:0], sdi_s[1]};
                        if (half)
                        begin
                            if (input_sample_phase)
                                rx_sh <= {rx_sh[30:0], sdi_s[1]};
                            if (bitcnt == last)
                                state <= ST_IDLE;
                            else
                            begin
                                bitcnt <= bitcnt + 6'h01;
                                sh     <= {sh[30:0], 1'b0};
                            end
                        end
                    end
                end
            endcase
        end
    end
endmodule // spcc_top
`default_nettype wire

/* File: bench/spcc_chk.sv */
// Port-level assertion checker for the serial port control block
`timescale 1ns/10ps
`default_nettype none
`include "spcc_consts.vh"
module spcc_chk
(
    input wire logic        mclk_in,
    input wire logic        reset_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        cpu_idle_in,
    input wire logic        select_n_in,
    input wire logic        sck_out,
    input wire logic        sck_oe_out,
    input wire logic        sdo_oe_out
);
    logic [31:0] ctl;
    wire         acc = psel_in && penable_in;
    // Shadow of the control register
    always @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            ctl <= 32'h0000_0000;
        else if (acc && pwrite_in && paddr_in == `SPCC_OFF_CTRL)
            ctl <= pwdata_in & 32'h0000_BFEF;
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    property p_off;
        !ctl[15] |-> !sck_oe_out && !sdo_oe_out;
    endproperty
    a_off: assert property (p_off) else $error("outputs driven while off");
    property p_mst;
        sck_oe_out == (ctl[15] && ctl[5]);
    endproperty
    a_mst: assert property (p_mst) else $error("clock drive not by role");
    property p_dis;
        ctl[12] |-> !sdo_oe_out;
    endproperty
    a_dis: assert property (p_dis) else $error("data pin driven when disowned");
    property p_drv;
        ctl[15] && ctl[5] && !ctl[12] |-> sdo_oe_out;
    endproperty
    a_drv: assert property (p_drv) else $error("master not driving data pin");
    property p_ss;
        (ctl[15] && !ctl[5] && ctl[7] && select_n_in)[*4] |-> !sdo_oe_out;
    endproperty
    a_ss: assert property (p_ss) else $error("unselected slave drives data");
    property p_idl;
        (ctl[15] && ctl[13] && cpu_idle_in)[*3] |=> $stable(sck_out);
    endproperty
    a_idl: assert property (p_idl) else $error("clock moves during idle halt");
    property p_pol;
        (!ctl[15] && $stable(ctl))[*2] |-> sck_out == ctl[6];
    endproperty
    a_pol: assert property (p_pol) else $error("clock idle level wrong");
    property p_rd;
        acc && !pwrite_in && paddr_in == `SPCC_OFF_CTRL |-> prdata_out == ctl;
    endproperty
    a_rd: assert property (p_rd) else $error("control readback wrong");
endmodule // spcc_chk
bind spcc_top spcc_chk u_chk (.mclk_in, .reset_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .cpu_idle_in, .select_n_in, .sck_out,
    .sck_oe_out, .sdo_oe_out);
`default_nettype wire

/* File: bench/spcc_far_slave.sv */
// Far-side serial slave model: returns a pattern and captures output
`timescale 1ns/10ps
`default_nettype none
module spcc_far_slave
(
    input  wire logic        sck_in,
    input  wire logic        sdo_in,
    input  wire logic        ckp_in,
    input  wire logic        cke_in,
    input  wire logic        clr_in,
    input  wire logic [5:0]  width_in,
    input  wire logic [31:0] pat_in,
    output var  logic        sdi_out,
    output var  logic [31:0] got_out,
    output var  logic [5:0]  cnt_out
);
    logic last = 1'b0;
    wire  act = sck_in ^ ckp_in;
    always @(act or clr_in)
    begin
        if (clr_in)
        begin
            got_out = 32'h0000_0000;
            cnt_out = 6'h00;
        end
        else if (act !== last && act === cke_in)
        begin
            got_out = {got_out[30:0], sdo_in};
            cnt_out = cnt_out + 6'h01;
        end
        last = act;
    end
    // Past the word the line shows the inverse of its last bit
    always @*
        sdi_out = (cnt_out < width_in) ? pat_in[width_in - 6'h01 - cnt_out] : ~pat_in[0];
endmodule // spcc_far_slave
`default_nettype wire

/* File: bench/spi_control_config_test.sv */
// Self-checking testbench for the serial port control block
`timescale 1ns/10ps
`default_nettype none
`include "spcc_consts.vh"
module spi_control_config_test;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        idle = 1'b0;
    logic        sck_x = 1'b0;
    logic        sdi_x = 1'b0;
    logic        sel_n = 1'b1;
    logic        slv = 1'b0;
    logic        clock_polarity = 1'b0;
    logic        cke = 1'b0;
    logic        clr = 1'b1;
    logic [5:0]  wid = 6'h08;
    logic [31:0] pat = 32'h0000_0000;
    logic [31:0] prd, got, rd;
    logic [5:0]  cnt;
    logic        perr, prdy, sck, sck_oe, sdo, sdo_oe, irq, m_sdi, er;
    int          errors = 0;
    int          comparisons = 0;
    wire         sdi = slv ? sdi_x : m_sdi;
    initial
    begin
        forever #20 mclk = ~mclk;
    end
    spcc_top u_dut
    (
        .mclk_in(mclk), .reset_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prd),
        .pready_out(prdy), .pslverr_out(perr), .cpu_idle_in(idle), .sck_in(sck_x),
        .sdi_in(sdi), .select_n_in(sel_n), .sck_out(sck), .sck_oe_out(sck_oe),
        .sdo_out(sdo), .sdo_oe_out(sdo_oe), .irq_out(irq)
    );
    spcc_far_slave u_far
    (
        .sck_in(sck), .sdo_in(sdo), .ckp_in(clock_polarity), .cke_in(cke), .clr_in(clr),
        .width_in(wid), .pat_in(pat), .sdi_out(m_sdi), .got_out(got), .cnt_out(cnt)
    );
    task automatic check(input logic [31:0] act, input logic [31:0] exp);
        comparisons++;
        if (act !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, act, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        pen <= 1'b1;
        do
        begin
            @(posedge mclk);
        end
        while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic t_regs;
        apb(0, `SPCC_OFF_CTRL, 0);
        check(rd, 32'h0000_0000);
        apb(1, `SPCC_OFF_CTRL, 32'hFFFF_FFFF);
        apb(0, `SPCC_OFF_CTRL, 0);
        check(rd, 32'h0000_BFEF);
        apb(1, `SPCC_OFF_CTRL, 0);
        apb(0, 8'h40, 0);
        check({31'h0, er}, 32'h1);
        $display("test regs done");
    endtask
    task automatic t_oe;
        logic [31:0] tv [4] = '{32'h0000_0020, 32'h0000_8020, 32'h0000_9020, 32'h0000_8080};
        logic [1:0]  ev [4] = '{2'b00, 2'b11, 2'b10, 2'b00};
        for (int i = 0; i < 4; i++)
        begin
            apb(1, `SPCC_OFF_CTRL, tv[i]);
            repeat (6) @(posedge mclk);
            check({30'h0, sck_oe, sdo_oe}, {30'h0, ev[i]});
        end
        $display("test pin ownership done");
    endtask
    task automatic t_xfer(input logic [31:0] ctl, input logic [5:0] w, input logic [31:0] d);
        logic [31:0] m;
        int n;
        m = (w == 6'd32) ? 32'hFFFF_FFFF : (32'h1 << w) - 1;
        clock_polarity = ctl[6];
        cke = ctl[8];
        wid = w;
        pat = ~d;
        clr = 1'b1;
        apb(1, `SPCC_OFF_CTRL, ctl & 32'hFFFF_7FFF);
        apb(1, `SPCC_OFF_CTRL, ctl);
        clr = 1'b0;
        apb(1, `SPCC_OFF_TXDATA, d);
        if (ctl[13])
        begin
            repeat (10) @(posedge mclk);
            idle <= 1'b1;
            repeat (3) @(posedge mclk);
            n = cnt;
            repeat (30) @(posedge mclk);
            check({26'h0, cnt}, n);
            idle <= 1'b0;
        end
        n = 0;
        do
        begin
            apb(0, `SPCC_OFF_STATUS, 0);
            n++;
        end
        while ((rd[16] !== 1'b0 || rd[10:8] !== 3'h0) && n < 100);
        check({28'h0, rd[16], rd[10:8]}, 32'h0);
        check(got & m, d & m);
        check({26'h0, cnt}, {26'h0, w});
        check({31'h0, sck}, {31'h0, ctl[6]});
        apb(0, `SPCC_OFF_RXDATA, 0);
        check(rd & m, ~d & m);
        $display("test transfer width %0d done", w);
    endtask
    task automatic t_slave;
        logic [7:0] d;
        d = 8'h96;
        slv = 1'b1;
        apb(1, `SPCC_OFF_CTRL, 32'h0000_8280);
        sel_n <= 1'b0;
        // Link clock of 320 ns: eight system clocks per bit
        for (int i = 7; i >= 0; i--)
        begin
            sdi_x <= d[i];
            repeat (2) @(posedge mclk);
            sck_x <= 1'b1;
            repeat (4) @(posedge mclk);
            sck_x <= 1'b0;
            repeat (2) @(posedge mclk);
        end
        sdi_x <= ~d[0];
        repeat (8) @(posedge mclk);
        check({31'h0, sdo_oe}, 32'h1);
        sel_n <= 1'b1;
        apb(0, `SPCC_OFF_RXDATA, 0);
        check(rd & 32'hFF, {24'h0, d});
        check({31'h0, sdo_oe}, 32'h0);
        slv = 1'b0;
        $display("test slave receive done");
    endtask
    task automatic t_framed;
        apb(1, `SPCC_OFF_AUX, 32'h1);
        apb(1, `SPCC_OFF_CTRL, 32'h0000_8120);
        apb(1, `SPCC_OFF_TXDATA, 32'h3C);
        repeat (2) @(posedge mclk);
        check({31'h0, sck}, 32'h1);
        repeat (40) @(posedge mclk);
        apb(0, `SPCC_OFF_RXDATA, 0);
        apb(1, `SPCC_OFF_AUX, 32'h0);
        $display("test framed mode done");
    endtask
    task automatic t_irq;
        apb(1, `SPCC_OFF_CTRL, 32'h0000_8021);
        apb(1, `SPCC_OFF_IRQCLR, 32'h7);
        apb(1, `SPCC_OFF_IRQEN, 32'h2);
        apb(1, `SPCC_OFF_TXDATA, 32'h5A);
        repeat (60) @(posedge mclk);
        check({31'h0, irq}, 32'h1);
        apb(1, `SPCC_OFF_IRQEN, 32'h0);
        @(posedge mclk);
        check({31'h0, irq}, 32'h0);
        apb(1, `SPCC_OFF_IRQEN, 32'h2);
        apb(0, `SPCC_OFF_RXDATA, 0);
        apb(1, `SPCC_OFF_IRQCLR, 32'h7);
        @(posedge mclk);
        check({31'h0, irq}, 32'h0);
        for (int m = 0; m < 4; m++)
        begin
            apb(1, `SPCC_OFF_CTRL, 32'h0000_8020 | (m << 2) | m);
            apb(1, `SPCC_OFF_IRQCLR, 32'h7);
            apb(0, `SPCC_OFF_STATUS, 0);
            check({30'h0, rd[1:0]}, {30'h0, m == 0, 1'b1});
        end
        $display("test interrupts done");
    endtask
    task automatic results;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #2_000_000;
        errors++;
        results;
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        t_regs;
        t_oe;
        t_xfer(32'h0000_8020, 6'd8, 32'h0000_00A5);
        t_xfer(32'h0000_8560, 6'd16, 32'h0000_C3A1);
        t_xfer(32'h0000_AD20, 6'd32, 32'h9E37_15C4);
        t_xfer(32'h0000_8220, 6'd8, 32'h0000_005C);
        t_framed;
        t_slave;
        t_irq;
        results;
    end
endmodule // spi_control_config_test
`default_nettype wire
